// File: inc/scob_pkg.sv
package scob_pkg;
    // Datapath geometry
    localparam int SCOB_WORD_W = 16;
    localparam int SCOB_AMT_W = 4;
    localparam int SCOB_HALF_W = 8;
    localparam int SCOB_LEVEL1_STEP = 4;
    localparam int SCOB_REG_ADDR_W = 8;
    localparam int SCOB_REG_DATA_W = 16;

    // Shift selection codes {shift_sel_hi, shift_sel_lo}
    localparam logic [1:0] SCOB_SEL_NONE = 2'h0;
    localparam logic [1:0] SCOB_SEL_RIGHT = 2'h1;
    localparam logic [1:0] SCOB_SEL_LEFT = 2'h2;
    localparam logic [1:0] SCOB_SEL_CIRC = 2'h3;

    // Microprogram word: opcode in the first four bits, literal in the low bits
    localparam int SCOB_OP_MSB = 15;
    localparam int SCOB_OP_LSB = 12;
    localparam int SCOB_LIT_MSB = 3;
    localparam int SCOB_LIT_LSB = 0;
    localparam logic [3:0] SCOB_OP_LIT_A = 4'hC;
    localparam logic [3:0] SCOB_OP_LIT_B = 4'hD;

    // Register map
    localparam logic [7:0] SCOB_ADDR_AMOUNT = 8'h00;
    localparam logic [7:0] SCOB_ADDR_BUFFER = 8'h04;
    localparam logic [7:0] SCOB_ADDR_STATUS = 8'h08;
    localparam int SCOB_AMOUNT_LSB = 0;
    localparam int SCOB_COMP_LSB = 4;
    localparam int SCOB_STAT_WRAP_BIT = 0;
    localparam int SCOB_STAT_RIGHT_BIT = 1;
    localparam int SCOB_STAT_LINES_LSB = 4;

    // Values after reset
    localparam logic [3:0] SCOB_AMT_RST = 4'h0;
    localparam logic [15:0] SCOB_WORD_RST = 16'h0000;
    localparam logic [7:0] SCOB_HALF_RST = 8'h00;
endpackage : scob_pkg

// File: verilog/scob_amount.sv
module scob_amount
    import scob_pkg::*;
#(
    parameter int AMT_W = SCOB_AMT_W
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic lit_load_i,
    input wire logic [AMT_W-1:0] lit_i,
    input wire logic shifter_load_i,
    input wire logic [AMT_W-1:0] shifter_i,
    input wire logic compl_load_i,
    input wire logic sw_load_i,
    input wire logic [AMT_W-1:0] sw_i,
    output logic [AMT_W-1:0] amount_o,
    output logic [AMT_W-1:0] complement_o
);
    logic [AMT_W-1:0] amount_q;
    logic [AMT_W-1:0] amount_d;

    generate
        if (AMT_W < 2)
        begin : g_bad_width
            $error("scob_amount: AMT_W must be at least 2");
        end
    endgenerate

    // Two's complement of the stored amount, modulo 2**AMT_W
    assign complement_o = (~amount_q) + {{(AMT_W-1){1'b0}}, 1'b1};

    // Literal beats shifter load; software write is last
    always_comb
    begin
        amount_d = amount_q;
        if (lit_load_i)
        begin
            amount_d = lit_i;
        end
        else if (shifter_load_i)
        begin
            amount_d = shifter_i;
        end
        else if (compl_load_i)
        begin
            amount_d = complement_o;
        end
        else if (sw_load_i)
        begin
            amount_d = sw_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            amount_q <= SCOB_AMT_RST;
        end
        else if (clear_i)
        begin
            amount_q <= SCOB_AMT_RST;
        end
        else
        begin
            amount_q <= amount_d;
        end
    end

    assign amount_o = amount_q;
endmodule : scob_amount

// File: verilog/scob_barrel.sv
module scob_barrel
    import scob_pkg::*;
#(
    parameter int W = SCOB_WORD_W,
    parameter int AMT_W = SCOB_AMT_W
)
(
    input wire logic [W-1:0] data_i,
    input wire logic [AMT_W-1:0] amount_i,
    input wire logic right_en_i,
    input wire logic wrap_en_i,
    output logic [W-1:0] data_o
);
    logic [W-1:0] level1;
    logic [W-1:0] rot;
    logic [AMT_W-3:0] amt_hi;
    logic [1:0] amt_lo;

    generate
        if (W != (1 << AMT_W) || AMT_W < 2)
        begin : g_bad_width
            $error("scob_barrel: W must equal 2**AMT_W");
        end
    endgenerate

    assign amt_hi = amount_i[AMT_W-1:2];
    assign amt_lo = amount_i[1:0];

    // Index 0 is the least significant bit; a right rotate by s
    // takes bit i from bit i+s. Wrapped bits land in the top s places.
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign level1[i] = data_i[(i + SCOB_LEVEL1_STEP * int'(amt_hi)) % W];
        assign rot[i] = level1[(i + int'(amt_lo)) % W];
        assign data_o[i] = rot[i] & ((i >= W - int'(amount_i)) ? wrap_en_i : right_en_i);
    end
endmodule : scob_barrel

// File: verilog/scob_top.sv
// Functional notes
// - Output buffer loads on phase-3 with load bit set, else holds.
// - Buffer bit n takes shifter output bit n, all sixteen.
// - Clear resets the output buffer to zero.
// - Buffer drives memory write data, device port and B-select.
// - Opcode 1100 or 1101 in microword loads literal into shift amount.
// - Shifter-load bit loads low four shifter bits into shift amount.
// - Select 00 none, 01 right end-off, 10 left end-off, 11 circular.
// - Amount bits 1,2 steer level one; bits 3,6 steer level two.
// - No shift forces amount lines zero, right high, wrap low.
// - Enable pair 01 left, 10 right, 11 circular; 00 never.
// - Right enable gates rightward data; wrap gates end-around data.
// - Zero amount in left sends zero; circular then drives right only.
// - Complement is the two's complement of the stored amount.
// - Low eight shifter bits feed address register and loop counter.
// - High eight shifter bits feed both base registers.
// - Complement bit reloads the amount with its own complement.
// - Level one moves by fours; level two moves by one to three.
//
// The register addresses and the strobed register port are this design's own decisions.
module scob_top
    import scob_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic CLEAR_I,
    input wire logic [SCOB_WORD_W-1:0] ADDER_OUT_I,
    input wire logic SHIFT_SEL_HI_I,
    input wire logic SHIFT_SEL_LO_I,
    input wire logic PHASE_THREE_CLOCK_I,
    input wire logic BUFFER_LOAD_BIT_I,
    input wire logic AMOUNT_FROM_SHIFTER_BIT_I,
    input wire logic AMOUNT_COMPLEMENT_BIT_I,
    input wire logic [SCOB_WORD_W-1:0] MICRO_WORD_I,
    input wire logic MICRO_WORD_VALID_I,
    input wire logic [SCOB_REG_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [SCOB_REG_DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WRITE_I,
    input wire logic REG_READ_I,
    output logic [SCOB_REG_DATA_W-1:0] REG_RDATA_O,
    output logic [SCOB_WORD_W-1:0] SHIFTER_OUT_O,
    output logic [SCOB_HALF_W-1:0] ADDR_CTR_SRC_O,
    output logic [SCOB_HALF_W-1:0] BASE_SRC_O,
    output logic [SCOB_WORD_W-1:0] DPM_WRITE_DATA_O,
    output logic [SCOB_WORD_W-1:0] DEVICE_PORT_DATA_O,
    output logic [SCOB_WORD_W-1:0] B_SELECT_DATA_O,
    output logic RIGHT_ENABLE_O,
    output logic WRAP_ENABLE_O,
    output logic [SCOB_AMT_W-1:0] SHIFT_LINES_O,
    output logic [SCOB_AMT_W-1:0] SHIFT_AMOUNT_O,
    output logic [SCOB_AMT_W-1:0] SHIFT_COMPLEMENT_O
);
    logic [1:0] shift_sel;
    logic [SCOB_AMT_W-1:0] amount;
    logic [SCOB_AMT_W-1:0] complement;
    logic [SCOB_AMT_W-1:0] lines;
    logic right_en;
    logic wrap_en;
    logic amt_zero;
    logic lit_load;
    logic sw_amount_wr;
    logic buf_load;
    logic [SCOB_WORD_W-1:0] shift_comb;
    logic [SCOB_WORD_W-1:0] mem_out_buffer_q;
    logic [SCOB_WORD_W-1:0] shifter_out_q;
    logic [SCOB_HALF_W-1:0] addr_ctr_src_q;
    logic [SCOB_HALF_W-1:0] base_src_q;
    logic right_en_q;
    logic wrap_en_q;
    logic [SCOB_AMT_W-1:0] lines_q;
    logic [SCOB_AMT_W-1:0] amount_q;
    logic [SCOB_AMT_W-1:0] complement_q;
    logic [SCOB_REG_DATA_W-1:0] rdata_q;
    logic [SCOB_REG_DATA_W-1:0] rdata_d;

    assign shift_sel = {SHIFT_SEL_HI_I, SHIFT_SEL_LO_I};
    assign lit_load = MICRO_WORD_VALID_I
        && (MICRO_WORD_I[SCOB_OP_MSB:SCOB_OP_LSB] == SCOB_OP_LIT_A
        || MICRO_WORD_I[SCOB_OP_MSB:SCOB_OP_LSB] == SCOB_OP_LIT_B);
    assign sw_amount_wr = REG_WRITE_I && (REG_ADDR_I == SCOB_ADDR_AMOUNT);
    assign buf_load = PHASE_THREE_CLOCK_I && BUFFER_LOAD_BIT_I;
    assign amt_zero = (amount == SCOB_AMT_RST);

    // Left shifts rely on the microprogram having stored the complement
    // first; this block does not negate on the fly.
    scob_amount #(
        .AMT_W(SCOB_AMT_W)
    ) u_amount (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .clear_i(CLEAR_I),
        .lit_load_i(lit_load),
        .lit_i(MICRO_WORD_I[SCOB_LIT_MSB:SCOB_LIT_LSB]),
        .shifter_load_i(AMOUNT_FROM_SHIFTER_BIT_I),
        .shifter_i(shift_comb[SCOB_AMT_W-1:0]),
        .compl_load_i(AMOUNT_COMPLEMENT_BIT_I),
        .sw_load_i(sw_amount_wr),
        .sw_i(REG_WDATA_I[SCOB_AMT_W-1:0]),
        .amount_o(amount),
        .complement_o(complement)
    );

    // Shift control decode
    always_comb
    begin
        lines = SCOB_AMT_RST;
        right_en = 1'b1;
        wrap_en = 1'b0;
        case (shift_sel)
            SCOB_SEL_NONE:
            begin
                lines = SCOB_AMT_RST;
                right_en = 1'b1;
                wrap_en = 1'b0;
            end
            SCOB_SEL_RIGHT:
            begin
                lines = amount;
                right_en = 1'b1;
                wrap_en = 1'b0;
            end
            SCOB_SEL_LEFT:
            begin
                lines = amount;
                right_en = 1'b0;
                wrap_en = 1'b1;
            end
            SCOB_SEL_CIRC:
            begin
                lines = amount;
                right_en = 1'b1;
                wrap_en = !amt_zero;
            end
            default:
            begin
                lines = SCOB_AMT_RST;
                right_en = 1'b1;
                wrap_en = 1'b0;
            end
        endcase
    end

    // lines[3:2] are amount bits 1,2; lines[1:0] are bits 3,6
    scob_barrel #(
        .W(SCOB_WORD_W),
        .AMT_W(SCOB_AMT_W)
    ) u_barrel (
        .data_i(ADDER_OUT_I),
        .amount_i(lines),
        .right_en_i(right_en),
        .wrap_en_i(wrap_en),
        .data_o(shift_comb)
    );

    // Output buffer
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            mem_out_buffer_q <= SCOB_WORD_RST;
        end
        else if (CLEAR_I)
        begin
            mem_out_buffer_q <= SCOB_WORD_RST;
        end
        else if (buf_load)
        begin
            mem_out_buffer_q <= shift_comb;
        end
    end

    // Registered shifter fan-out
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            shifter_out_q <= SCOB_WORD_RST;
            addr_ctr_src_q <= SCOB_HALF_RST;
            base_src_q <= SCOB_HALF_RST;
        end
        else
        begin
            shifter_out_q <= shift_comb;
            addr_ctr_src_q <= shift_comb[SCOB_HALF_W-1:0];
            base_src_q <= shift_comb[SCOB_WORD_W-1:SCOB_HALF_W];
        end
    end

    // Observation copies of the control lines
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            right_en_q <= 1'b1;
            wrap_en_q <= 1'b0;
            lines_q <= SCOB_AMT_RST;
            amount_q <= SCOB_AMT_RST;
            complement_q <= SCOB_AMT_RST;
        end
        else
        begin
            right_en_q <= right_en;
            wrap_en_q <= wrap_en;
            lines_q <= lines;
            amount_q <= amount;
            complement_q <= complement;
        end
    end

    // Register read port; unmapped addresses read zero
    always_comb
    begin
        rdata_d = '0;
        case (REG_ADDR_I)
            SCOB_ADDR_AMOUNT:
            begin
                rdata_d[SCOB_AMOUNT_LSB +: SCOB_AMT_W] = amount;
                rdata_d[SCOB_COMP_LSB +: SCOB_AMT_W] = complement;
            end
            SCOB_ADDR_BUFFER:
            begin
                rdata_d = mem_out_buffer_q;
            end
            SCOB_ADDR_STATUS:
            begin
                rdata_d[SCOB_STAT_WRAP_BIT] = wrap_en;
                rdata_d[SCOB_STAT_RIGHT_BIT] = right_en;
                rdata_d[SCOB_STAT_LINES_LSB +: SCOB_AMT_W] = lines;
            end
            default:
            begin
                rdata_d = '0;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rdata_q <= '0;
        end
        else if (REG_READ_I)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign SHIFTER_OUT_O = shifter_out_q;
    assign ADDR_CTR_SRC_O = addr_ctr_src_q;
    assign BASE_SRC_O = base_src_q;
    assign DPM_WRITE_DATA_O = mem_out_buffer_q;
    assign DEVICE_PORT_DATA_O = mem_out_buffer_q;
    assign B_SELECT_DATA_O = mem_out_buffer_q;
    assign RIGHT_ENABLE_O = right_en_q;
    assign WRAP_ENABLE_O = wrap_en_q;
    assign SHIFT_LINES_O = lines_q;
    assign SHIFT_AMOUNT_O = amount_q;
    assign SHIFT_COMPLEMENT_O = complement_q;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    buf_load_a:
        assert property (buf_load && !CLEAR_I
            |=> DPM_WRITE_DATA_O == $past(shift_comb))
        else $error("buffer missed a load");

    buf_hold_a:
        assert property (!buf_load && !CLEAR_I |=> $stable(mem_out_buffer_q))
        else $error("buffer changed without a load");

    // Unshifted loads must land bit for bit, so any swap in the fan-out shows up
    buf_bits_a:
        assert property (buf_load && !CLEAR_I && shift_sel == SCOB_SEL_NONE
            |=> B_SELECT_DATA_O == $past(ADDER_OUT_I))
        else $error("buffer bit order wrong");

    buf_clear_a:
        assert property (CLEAR_I |=> mem_out_buffer_q == SCOB_WORD_RST
            && DEVICE_PORT_DATA_O == SCOB_WORD_RST)
        else $error("clear left buffer non-zero");

    lit_load_a:
        assert property (lit_load && !CLEAR_I
            |=> amount == $past(MICRO_WORD_I[SCOB_LIT_MSB:SCOB_LIT_LSB]))
        else $error("literal not loaded");

    shf_load_a:
        assert property (AMOUNT_FROM_SHIFTER_BIT_I && !lit_load && !CLEAR_I
            |=> amount == $past(shift_comb[SCOB_AMT_W-1:0]))
        else $error("shifter load not taken");

    right_shift_a:
        assert property (shift_sel == SCOB_SEL_RIGHT |-> shift_comb == (ADDER_OUT_I >> amount))
        else $error("right end-off result wrong");

    left_shift_a:
        assert property (shift_sel == SCOB_SEL_LEFT && !amt_zero
            |-> shift_comb == (ADDER_OUT_I << complement))
        else $error("left end-off result wrong");

    circ_shift_a:
        assert property (shift_sel == SCOB_SEL_CIRC
            |-> shift_comb == ((ADDER_OUT_I >> amount) | (ADDER_OUT_I << complement)))
        else $error("circular result wrong");

    no_shift_a:
        assert property (shift_sel == SCOB_SEL_NONE
            |-> lines == SCOB_AMT_RST && right_en && !wrap_en && shift_comb == ADDER_OUT_I)
        else $error("no-shift controls wrong");

    enable_pair_a:
        assert property (RIGHT_ENABLE_O || WRAP_ENABLE_O)
        else $error("both enables low");

    zero_circ_a:
        assert property (shift_sel == SCOB_SEL_CIRC && amt_zero
            |=> RIGHT_ENABLE_O && !WRAP_ENABLE_O && SHIFT_LINES_O == SCOB_AMT_RST)
        else $error("zero circular controls wrong");

    comp_value_a:
        assert property (SHIFT_AMOUNT_O + SHIFT_COMPLEMENT_O == SCOB_AMT_RST)
        else $error("complement does not cancel amount");

    fan_out_a:
        assert property (ADDR_CTR_SRC_O == SHIFTER_OUT_O[SCOB_HALF_W-1:0]
            && BASE_SRC_O == SHIFTER_OUT_O[SCOB_WORD_W-1:SCOB_HALF_W])
        else $error("fan-out halves wrong");

    comp_load_a:
        assert property (AMOUNT_COMPLEMENT_BIT_I && !lit_load && !AMOUNT_FROM_SHIFTER_BIT_I
            && !CLEAR_I ##1 1'b1 |-> amount == $past(complement))
        else $error("complement reload wrong");

    lit_first_a:
        assert property (lit_load && AMOUNT_FROM_SHIFTER_BIT_I && !CLEAR_I
            |=> amount == $past(MICRO_WORD_I[SCOB_LIT_MSB:SCOB_LIT_LSB]))
        else $error("literal lost priority");

    read_pulse_a:
        assert property (!REG_READ_I |=> REG_RDATA_O == '0)
        else $error("read data outside its cycle");
endmodule : scob_top

// File: dv/scob_seq_model.sv
module scob_seq_model
    import scob_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [SCOB_WORD_W-1:0] cmd_word_i,
    input wire logic cmd_word_valid_i,
    input wire logic [5:0] cmd_ctl_i,
    output logic sel_hi_o,
    output logic sel_lo_o,
    output logic phase3_o,
    output logic buf_load_o,
    output logic amt_shl_o,
    output logic amt_cmp_o,
    output logic [SCOB_WORD_W-1:0] word_o,
    output logic word_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [11:0] idle_q;

    // Idle word keeps moving so a stale literal never looks fresh
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            idle_q <= 12'h000;
        else
            idle_q <= idle_q + 12'h001;
    end

    always_comb
    begin
        {sel_hi_o, sel_lo_o, phase3_o, buf_load_o, amt_shl_o, amt_cmp_o} =
            cmd_valid_i ? cmd_ctl_i : 6'h00;
        word_o = cmd_valid_i ? cmd_word_i : {4'h0, idle_q};
        word_valid_o = cmd_valid_i & cmd_word_valid_i;
    end
endmodule : scob_seq_model

// File: dv/scob_tb_top.sv
module scob_tb_top
    import scob_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [5:0] C_SHL = 6'h02;
    localparam logic [5:0] C_CMP = 6'h01;

    logic clk;
    logic rst_n = 1'b0;
    logic clear = 1'b0;
    logic [15:0] adder = 16'h0000;
    logic cmd_v = 1'b0;
    logic cmd_wv = 1'b0;
    logic [15:0] cmd_w = 16'h0000;
    logic [5:0] cmd_c = 6'h00;
    logic [7:0] ra = 8'h00;
    logic [15:0] rwd = 16'h0000;
    logic rwr = 1'b0;
    logic rrd = 1'b0;
    logic s_hi, s_lo, p3, bl, shl, cmp, mvalid, ren, wen;
    logic [15:0] mword, rdata, sh_out, data_program_store, dev, bsel, e;
    logic [7:0] lo8, hi8;
    logic [3:0] lines, amt, cmpl;
    int fail_count = 0;
    int n_compared = 0;
    logic [3:0] amts [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hB, 4'hF};
    logic [15:0] pats [6] = '{16'hA5C3, 16'h8001, 16'hF00F, 16'h1234, 16'hFFFF, 16'h8000};

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    scob_seq_model scob_seq_model_inst (
        .clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_v), .cmd_word_i(cmd_w),
        .cmd_word_valid_i(cmd_wv), .cmd_ctl_i(cmd_c), .sel_hi_o(s_hi), .sel_lo_o(s_lo),
        .phase3_o(p3), .buf_load_o(bl), .amt_shl_o(shl), .amt_cmp_o(cmp),
        .word_o(mword), .word_valid_o(mvalid)
    );

    scob_top scob_top_inst (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .CLEAR_I(clear), .ADDER_OUT_I(adder),
        .SHIFT_SEL_HI_I(s_hi), .SHIFT_SEL_LO_I(s_lo), .PHASE_THREE_CLOCK_I(p3),
        .BUFFER_LOAD_BIT_I(bl), .AMOUNT_FROM_SHIFTER_BIT_I(shl),
        .AMOUNT_COMPLEMENT_BIT_I(cmp), .MICRO_WORD_I(mword), .MICRO_WORD_VALID_I(mvalid),
        .REG_ADDR_I(ra), .REG_WDATA_I(rwd), .REG_WRITE_I(rwr), .REG_READ_I(rrd),
        .REG_RDATA_O(rdata), .SHIFTER_OUT_O(sh_out), .ADDR_CTR_SRC_O(lo8),
        .BASE_SRC_O(hi8), .DPM_WRITE_DATA_O(data_program_store), .DEVICE_PORT_DATA_O(dev),
        .B_SELECT_DATA_O(bsel), .RIGHT_ENABLE_O(ren), .WRAP_ENABLE_O(wen),
        .SHIFT_LINES_O(lines), .SHIFT_AMOUNT_O(amt), .SHIFT_COMPLEMENT_O(cmpl)
    );

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One control word for one cycle, then idle; outputs sampled after the taking edge
    task automatic cyc(input logic [15:0] w, input logic wv, input logic [5:0] c,
                       input logic [15:0] d);
        @(posedge clk);
        cmd_v <= 1'b1;
        cmd_w <= w;
        cmd_wv <= wv;
        cmd_c <= c;
        adder <= d;
        @(posedge clk);
        cmd_v <= 1'b0;
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1;
        check(rdata, x);
    endtask : rdc

    function automatic logic [15:0] lit(logic [3:0] a, logic odd);
        return {(odd ? SCOB_OP_LIT_B : SCOB_OP_LIT_A), 8'h00, a};
    endfunction : lit

    function automatic logic [15:0] amt_reg(logic [3:0] a);
        return {8'h00, 4'h0 - a, a};
    endfunction : amt_reg

    function automatic logic [15:0] shf(logic [15:0] d, logic [1:0] s, logic [3:0] a);
        case (s)
            SCOB_SEL_RIGHT: return d >> a;
            SCOB_SEL_LEFT: return (a == 4'h0) ? 16'h0000 : d << (5'd16 - a);
            SCOB_SEL_CIRC: return (d >> a) | (d << (5'd16 - a));
            default: return d;
        endcase
    endfunction : shf

    // Result is {right, wrap, lines}
    function automatic logic [5:0] ens(logic [1:0] s, logic [3:0] a);
        if (s == SCOB_SEL_NONE || a == 4'h0)
            return (s == SCOB_SEL_LEFT) ? 6'h10 : 6'h20;
        return {s != SCOB_SEL_LEFT, s != SCOB_SEL_RIGHT, a};
    endfunction : ens

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({15'h0000, ren}, 16'h0001);
        check(data_program_store, SCOB_WORD_RST);
        for (int s = 0; s < 4; s++)
        begin
            foreach (amts[i])
            begin
                cyc(lit(amts[i], i[0]), 1'b1, 6'h00, 16'h0000);
                cyc(16'h0000, 1'b0, {s[1:0], 4'hC}, pats[i]);
                e = shf(pats[i], s[1:0], amts[i]);
                check(sh_out, e);
                check({10'h000, ren, wen, lines}, {10'h000, ens(s[1:0], amts[i])});
                check(data_program_store, e);
                check(dev, e);
                check(bsel, e);
                check({lo8, hi8}, {e[7:0], e[15:8]});
                check({8'h00, cmpl, amt}, amt_reg(amts[i]));
            end
        end
        // Load bit or phase alone must not disturb the buffer
        cyc(16'h0000, 1'b0, 6'h04, 16'h5555);
        check(data_program_store, e);
        cyc(16'h0000, 1'b0, 6'h08, 16'h5555);
        check(data_program_store, e);
        wr(SCOB_ADDR_BUFFER, 16'hFFFF);
        rdc(SCOB_ADDR_BUFFER, e);
        @(posedge clk);
        #1;
        check(rdata, 16'h0000);
        rdc(8'h20, 16'h0000);
        cyc(16'h0000, 1'b0, C_SHL, 16'h1237);
        rdc(SCOB_ADDR_AMOUNT, amt_reg(4'h7));
        cyc(16'h0000, 1'b0, C_CMP, 16'h0000);
        rdc(SCOB_ADDR_AMOUNT, amt_reg(4'h9));
        cyc(lit(4'h6, 1'b0), 1'b1, C_SHL, 16'h0009);
        rdc(SCOB_ADDR_AMOUNT, amt_reg(4'h6));
        cyc({4'hE, 8'h00, 4'h3}, 1'b1, 6'h00, 16'h0000);
        cyc(lit(4'h3, 1'b1), 1'b0, 6'h00, 16'h0000);
        rdc(SCOB_ADDR_AMOUNT, amt_reg(4'h6));
        // Left by three: literal, then complement, then the left selection
        cyc(lit(4'h3, 1'b0), 1'b1, 6'h00, 16'h0000);
        cyc(16'h0000, 1'b0, C_CMP, 16'h0000);
        cyc(16'h0000, 1'b0, {SCOB_SEL_LEFT, 4'hC}, 16'h0F0F);
        check(sh_out, 16'h7878);
        check(data_program_store, 16'h7878);
        wr(SCOB_ADDR_AMOUNT, 16'h0005);
        rdc(SCOB_ADDR_AMOUNT, amt_reg(4'h5));
        rdc(SCOB_ADDR_STATUS, 16'h0002);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        #1;
        check(data_program_store, 16'h0000);
        rdc(SCOB_ADDR_AMOUNT, 16'h0000);
        close_out();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule : scob_tb_top
